// file: hw/irc_regs.sv
// Identification, soft reset, calibration and monitor-select register bank.
// Contract
// - Read-only 12-bit part number: bits 11:4 at 0x86, bits 3:0 high nibble of 0x87.
// - Read-only 4-bit revision code in low nibble of 0x87.
// - Writing one to soft reset bit resets all logic like the reset pin.
// - Clock outputs are disabled while soft reset is in effect.
// - Writing one to calibration trigger starts calibration; bit clears itself.
// - Calibration done is shown by lock-loss alarm going low.
// - Input frequency shift over 500 ppm may start calibration autonomously.
// - Quick-lock bit one enables dynamic loop bandwidth during acquisition.
// - Monitor selector: 00 off, 01 reserved, 10 slow, 11 normal.
// - Slow monitor detects loss more slowly and less sensitively.
// - Upper selector bits at 0x8a: input two bit 1, input one bit 0.
// - Lower selector bits at 0x8b bits 5 and 4; that register resets all ones.
// - Lock-loss status reads zero when locked, one when unlocked.
`timescale 1ns/1ps
module irc_regs
   import irc_pkg::*;
#(
   parameter logic [11:0] PART_NUMBER = 12'h0a5, // Arbitrary value.
   parameter logic [3:0] REVISION = 4'h1, // Arbitrary value.
   parameter int SOFT_RESET_HOLD = SOFT_RESET_CYCLES, // Soft reset length in cycles.
   parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT // Calibration length in cycles.
) (
   input wire logic clk, // 40 MHz internal clock.
   input wire logic reset_n, // Asynchronous reset pin, active low.
   input wire logic [ADDR_W-1:0] reg_addr, // Register address.
   input wire logic [DATA_W-1:0] reg_wdata, // Write data.
   input wire logic reg_write, // Write strobe, one cycle.
   output logic [DATA_W-1:0] reg_rdata, // Read data for reg_addr.
   input wire logic freq_shift, // Pin: input moved over 500 ppm.
   output logic soft_reset_active, // Internal logic held in reset.
   output logic clock_out_enable, // Clock outputs enabled.
   output logic cal_running, // Self-calibration in progress.
   output logic lock_loss_alarm, // High while unlocked.
   output logic quick_lock_enable, // Dynamic loop bandwidth allowed.
   output irc_mon_mode_s input_one_monitor, // Decoded input one monitor mode.
   output irc_mon_mode_s input_two_monitor // Decoded input two monitor mode.
);

   typedef struct packed {
      irc_mode_e mode;
      logic [CNT_W-1:0] count;
      logic quick_lock;
      irc_mon_sel_s sel;
      logic [1:0] shift_sync;
      logic shift_seen;
      logic unlocked;
      logic [DATA_W-1:0] rdata;
   } irc_state_s;

   irc_state_s state_r;
   irc_state_s state_nxt;

   function automatic irc_mon_mode_s decode_mon(input logic [1:0] code);
      irc_mon_mode_s m;
      m.off = (code == MON_OFF);
      m.slow = (code == MON_SLOW);
      m.normal = (code == MON_NORMAL);
      return m;
   endfunction

   logic wr_ctrl;
   logic rise_shift;
   assign wr_ctrl = reg_write && (reg_addr == ADDR_RESET_CAL) && (state_r.mode != IRC_SOFT_RESET);
   assign rise_shift = state_r.shift_sync[1] && !state_r.shift_seen;

   always_comb begin
      state_nxt = state_r;
      state_nxt.shift_sync = {state_r.shift_sync[0], freq_shift};
      state_nxt.shift_seen = state_r.shift_sync[1];
      unique case (state_r.mode)
         IRC_RUN: begin
            if (rise_shift) begin
               state_nxt.mode = IRC_CALIBRATE;
               state_nxt.unlocked = 1'b1;
               state_nxt.count = '0;
            end
         end
         IRC_CALIBRATE: begin
            // Counter stands in for the analog sequence; lock follows its end.
            if (state_r.count == CNT_W'(CAL_CYCLES - 1)) begin
               state_nxt.mode = IRC_RUN;
               state_nxt.unlocked = 1'b0;
            end else begin
               state_nxt.count = state_r.count + 1'b1;
            end
         end
         IRC_SOFT_RESET: begin
            // Registers return to reset values at the end so the host sees defaults.
            if (state_r.count == CNT_W'(SOFT_RESET_HOLD - 1)) begin
               state_nxt = '0;
               state_nxt.sel = {MON_SEL_RESET, MON_SEL_RESET};
               state_nxt.unlocked = 1'b1;
            end else begin
               state_nxt.count = state_r.count + 1'b1;
            end
         end
         default: state_nxt.mode = IRC_RUN;
      endcase
      if (wr_ctrl && reg_wdata[SOFT_RESET_BIT]) begin
         state_nxt.mode = IRC_SOFT_RESET;
         state_nxt.count = '0;
      end else if (wr_ctrl && reg_wdata[CAL_TRIGGER_BIT]) begin
         state_nxt.mode = IRC_CALIBRATE;
         state_nxt.unlocked = 1'b1;
         state_nxt.count = '0;
      end
      if (reg_write && state_r.mode != IRC_SOFT_RESET) begin
         if (reg_addr == ADDR_QUICK_LOCK) begin
            state_nxt.quick_lock = reg_wdata[QUICK_LOCK_BIT];
         end
         if (reg_addr == ADDR_MON_SEL_HIGH) begin
            state_nxt.sel.in_one[1] = reg_wdata[MON_HIGH_IN1_BIT];
            state_nxt.sel.in_two[1] = reg_wdata[MON_HIGH_IN2_BIT];
         end
         if (reg_addr == ADDR_MON_SEL_LOW) begin
            state_nxt.sel.in_one[0] = reg_wdata[MON_LOW_IN1_BIT];
            state_nxt.sel.in_two[0] = reg_wdata[MON_LOW_IN2_BIT];
         end
      end
      state_nxt.rdata = ZERO_BYTE;
      unique case (reg_addr)
         ADDR_PART_HIGH: state_nxt.rdata = PART_NUMBER[11:4];
         ADDR_PART_LOW_REV: state_nxt.rdata = {PART_NUMBER[3:0], REVISION};
         ADDR_RESET_CAL: state_nxt.rdata = ZERO_BYTE;
         ADDR_QUICK_LOCK: state_nxt.rdata = {7'h00, state_r.quick_lock};
         ADDR_MON_SEL_HIGH: state_nxt.rdata = {6'h00, state_r.sel.in_two[1],
            state_r.sel.in_one[1]};
         ADDR_MON_SEL_LOW: state_nxt.rdata = {2'h3, state_r.sel.in_two[0],
            state_r.sel.in_one[0], 4'hf};
         default: state_nxt.rdata = ZERO_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= '0;
         state_r.sel <= {MON_SEL_RESET, MON_SEL_RESET};
         state_r.unlocked <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata = state_r.rdata;
   assign soft_reset_active = (state_r.mode == IRC_SOFT_RESET);
   assign clock_out_enable = (state_r.mode != IRC_SOFT_RESET);
   assign cal_running = (state_r.mode == IRC_CALIBRATE);
   assign lock_loss_alarm = state_r.unlocked;
   assign quick_lock_enable = state_r.quick_lock && cal_running;
   assign input_one_monitor = decode_mon(state_r.sel.in_one);
   assign input_two_monitor = decode_mon(state_r.sel.in_two);
endmodule

// file: hw/irc_pkg.sv
// Package with register map, field positions and timing constants of the ident/reset/cal bank.
package irc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_PART_HIGH = 8'h86;
   localparam logic [7:0] ADDR_PART_LOW_REV = 8'h87;
   localparam logic [7:0] ADDR_RESET_CAL = 8'h88;
   localparam logic [7:0] ADDR_QUICK_LOCK = 8'h89;
   localparam logic [7:0] ADDR_MON_SEL_HIGH = 8'h8a;
   localparam logic [7:0] ADDR_MON_SEL_LOW = 8'h8b;
   localparam int SOFT_RESET_BIT = 7;
   localparam int CAL_TRIGGER_BIT = 6;
   localparam int QUICK_LOCK_BIT = 0;
   localparam int MON_HIGH_IN1_BIT = 0;
   localparam int MON_HIGH_IN2_BIT = 1;
   localparam int MON_LOW_IN1_BIT = 4;
   localparam int MON_LOW_IN2_BIT = 5;
   localparam logic [7:0] MON_LOW_RESET = 8'hff;
   localparam logic [1:0] MON_SEL_RESET = 2'h3;
   localparam logic [1:0] MON_OFF = 2'h0;
   localparam logic [1:0] MON_SLOW = 2'h2;
   localparam logic [1:0] MON_NORMAL = 2'h3;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Soft reset is held long enough to cover the host's 10 ms quiet period.
   localparam int SOFT_RESET_MS = 10;
   localparam int CLK_KHZ = 40000;
   localparam int SOFT_RESET_CYCLES = SOFT_RESET_MS * CLK_KHZ;
   localparam int CAL_CYCLES_DEFAULT = 1024;
   localparam int CNT_W = 24;

   typedef enum logic [1:0] {
      IRC_RUN = 2'b00,
      IRC_SOFT_RESET = 2'b01,
      IRC_CALIBRATE = 2'b10
   } irc_mode_e;

   typedef struct packed {
      logic [1:0] in_one;
      logic [1:0] in_two;
   } irc_mon_sel_s;

   typedef struct packed {
      logic off;
      logic slow;
      logic normal;
   } irc_mon_mode_s;
endpackage

// file: test/irc_regs_asserts.sv
// Checker for the ident, reset and calibration register bank ports.
`timescale 1ns/1ps
module irc_regs_asserts
   import irc_pkg::*;
#(parameter logic [11:0] PART_NUMBER = 12'h0a5, parameter logic [3:0] REVISION = 4'h1) (
   input wire logic clk, // Clock.
   input wire logic reset_n, // Reset.
   input wire logic [ADDR_W-1:0] reg_addr, // Address.
   input wire logic [DATA_W-1:0] reg_wdata, // Data.
   input wire logic reg_write, // Strobe.
   input wire logic [DATA_W-1:0] reg_rdata, // Read data.
   input wire logic freq_shift, // Shift pin.
   input wire logic soft_reset_active, // Soft reset.
   input wire logic clock_out_enable, // Out enable.
   input wire logic cal_running, // Cal busy.
   input wire logic lock_loss_alarm, // Unlocked.
   input wire logic quick_lock_enable, // Quick lock.
   input wire irc_mon_mode_s input_one_monitor, // Mode one.
   input wire irc_mon_mode_s input_two_monitor // Mode two.
);
   localparam logic [7:0] ID_HI = PART_NUMBER[11:4];
   localparam logic [7:0] ID_LO = {PART_NUMBER[3:0], REVISION};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Writes are refused during soft reset, so only accepted ones count.
   wire ctl_wr = reg_write && reg_addr == ADDR_RESET_CAL && !soft_reset_active;
   a_part_high: assert property (reg_addr == ADDR_PART_HIGH |=> reg_rdata == ID_HI)
      else $error("part number high byte wrong");
   a_part_low: assert property (reg_addr == ADDR_PART_LOW_REV |=> reg_rdata == ID_LO)
      else $error("part number low or revision wrong");
   a_ctrl_zero: assert property (reg_addr == ADDR_RESET_CAL |=> reg_rdata == ZERO_BYTE)
      else $error("control register not zero");
   a_clock_off: assert property (soft_reset_active |-> !clock_out_enable)
      else $error("clock outputs on in soft reset");
   a_soft_start: assert property (ctl_wr && reg_wdata[SOFT_RESET_BIT] |=> soft_reset_active)
      else $error("soft reset not taken");
   a_cal_start: assert property (ctl_wr && reg_wdata[7:6] == 2'h1 |=> cal_running && lock_loss_alarm)
      else $error("calibration not started");
   a_cal_done: assert property ($fell(cal_running) && !soft_reset_active |-> !lock_loss_alarm)
      else $error("alarm high after calibration");
   a_quick_cal: assert property (quick_lock_enable |-> cal_running)
      else $error("quick lock outside acquisition");
endmodule
bind irc_regs irc_regs_asserts #(.PART_NUMBER(PART_NUMBER), .REVISION(REVISION)) u_chk (.*);

// file: test/irc_host.sv
// Host controller model on the register port.
`timescale 1ns/1ps
module irc_host
   import irc_pkg::*;
(
   input wire logic clk, // Clock.
   output logic [ADDR_W-1:0] reg_addr, // Address.
   output logic [DATA_W-1:0] reg_wdata, // Data.
   output logic reg_write, // Strobe.
   input wire logic [DATA_W-1:0] reg_rdata // Read data.
);
   initial {reg_addr, reg_wdata, reg_write} = '0;
   // One access per call; the strobe is a single cycle and read data lands one edge later.
   task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = w;
      @(negedge clk);
      reg_write = 1'h0;
      q = reg_rdata;
   endtask
endmodule

// file: test/irc_regs_tb.sv
// Self-checking bench for the ident, reset and calibration register bank.
`timescale 1ns/1ps
module irc_regs_tb;
   import irc_pkg::*;
   localparam logic [11:0] PN = 12'h0a5; // Arbitrary value.
   localparam logic [3:0] RV = 4'h1; // Arbitrary value.
   localparam int SRH = 20;
   localparam int CAL = 16;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic freq_shift = 1'h0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   logic reg_write, soft_reset_active, clock_out_enable, cal_running, lock_loss_alarm;
   logic quick_lock_enable;
   irc_mon_mode_s input_one_monitor, input_two_monitor;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   wire [7:0] st = {5'h00, quick_lock_enable, cal_running, lock_loss_alarm};
   always #12.5 clk = ~clk;
   irc_regs #(.PART_NUMBER(PN), .REVISION(RV), .SOFT_RESET_HOLD(SRH), .CAL_CYCLES(CAL)) dut (.*);
   irc_host host (.*);
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Counts cycles a busy output stays high, bounded so a stuck flag cannot hang the run.
   task automatic span(input bit sr);
      n = 0;
      while ((sr ? soft_reset_active : cal_running) === 1'h1 && n < 999) begin
         n++;
         @(negedge clk);
      end
   endtask
   function automatic logic [7:0] dec(input logic [1:0] s);
      return {5'h00, s == MON_OFF, s == MON_SLOW, s == MON_NORMAL};
   endfunction
   task automatic t_ident;
      host.xfer(ADDR_PART_HIGH, ZERO_BYTE, 1'h0, q);
      chk("part_high", q, PN[11:4]);
      host.xfer(ADDR_PART_LOW_REV, ZERO_BYTE, 1'h0, q);
      chk("part_low_rev", q, {PN[3:0], RV});
      host.xfer(ADDR_MON_SEL_LOW, ZERO_BYTE, 1'h0, q);
      chk("mon_low_reset", q, MON_LOW_RESET);
      host.xfer(8'h90, ZERO_BYTE, 1'h0, q);
      chk("unmapped", q, ZERO_BYTE);
      $display("ident test done");
   endtask
   task automatic t_mon;
      logic [1:0] a, b;
      for (int k = 0; k < 4; k++) begin
         a = 2'(k);
         b = ~a;
         host.xfer(ADDR_MON_SEL_HIGH, {6'h00, b[1], a[1]}, 1'h1, q);
         host.xfer(ADDR_MON_SEL_LOW, {2'h0, b[0], a[0], 4'h0}, 1'h1, q);
         chk("mon_one", 8'(input_one_monitor), dec(a));
         chk("mon_two", 8'(input_two_monitor), dec(b));
      end
      // Last pass leaves input one at 11 and input two at 00.
      host.xfer(ADDR_MON_SEL_HIGH, ZERO_BYTE, 1'h0, q);
      chk("mon_high_read", q, 8'h01);
      host.xfer(ADDR_MON_SEL_LOW, ZERO_BYTE, 1'h0, q);
      chk("mon_low_read", q, 8'hdf);
      $display("monitor test done");
   endtask
   task automatic t_cal;
      host.xfer(ADDR_QUICK_LOCK, 8'h01, 1'h1, q);
      host.xfer(ADDR_RESET_CAL, ZERO_BYTE, 1'h1, q);
      chk("zero_trigger", st, 8'h01);
      host.xfer(ADDR_RESET_CAL, 8'h40, 1'h1, q);
      chk("cal_start", st, 8'h07);
      span(1'b0);
      chk("cal_len", 8'(n), 8'(CAL));
      chk("cal_end", st, ZERO_BYTE);
      host.xfer(ADDR_RESET_CAL, ZERO_BYTE, 1'h0, q);
      chk("trigger_read", q, ZERO_BYTE);
      host.xfer(ADDR_QUICK_LOCK, ZERO_BYTE, 1'h0, q);
      chk("quick_read", q, 8'h01);
      freq_shift = 1'h1;
      n = 0;
      while (cal_running !== 1'h1 && n < 8) begin
         n++;
         @(negedge clk);
      end
      chk("auto_cal", 8'(cal_running), 8'h01);
      freq_shift = 1'h0;
      span(1'b0);
      $display("calibration test done");
   endtask
   task automatic t_soft;
      host.xfer(ADDR_RESET_CAL, 8'hc0, 1'h1, q);
      chk("soft_on", {5'h00, soft_reset_active, clock_out_enable, cal_running}, 8'h04);
      span(1'b1);
      chk("soft_len", 8'(n), 8'(SRH));
      chk("soft_end", st, 8'h01);
      chk("mon_two_reset", 8'(input_two_monitor), dec(MON_NORMAL));
      host.xfer(ADDR_QUICK_LOCK, ZERO_BYTE, 1'h0, q);
      chk("quick_reset", q, ZERO_BYTE);
      $display("soft reset test done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #50 reset_n = 1'h1;
      t_ident;
      t_mon;
      t_cal;
      t_soft;
      stop_test;
   end
   initial begin
      #20000;
      mismatches++;
      stop_test;
   end
endmodule
